/* File: sdsd_checker.sv */
// Port assertions for the segment display scan driver
`timescale 1ns/10ps
module sdsd_checker
  import sdsd_pkg::*;
(
  // Clock, reset and register port
  input  wire logic         clock_i,
  input  wire logic         arst_n_i,
  input  wire logic [11:0]  addr_i,
  input  wire logic [7:0]   wdata_i,
  input  wire logic         wr_i,
  input  wire logic         rd_i,
  input  wire logic [7:0]   rdata_o,
  // Display side
  input  wire logic [7:0]   com_o,
  input  wire logic [27:0]  seg_o,
  input  wire logic [31:0]  pin_display_en_o,
  input  wire logic [1:0]   divider_res_o,
  input  wire logic         bias_third_o,
  input  wire logic         led_mode_o,
  input  wire logic [3:0]   vlcd_o
);
  localparam int SLOT = 19520;
  logic [7:0]  prev_q, prev_d; // Common seen last cycle
  logic [15:0] cnt_q, cnt_d;   // Cycles since last common change
  logic        sw;             // Step from one common to the next
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // Restart the count at every common change
  always_comb begin
    prev_d = com_o;
    cnt_d  = (com_o != prev_q) ? 16'h0000 : cnt_q + 16'h0001;
  end
  // Register the helper state
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_q <= 8'h00;
      cnt_q  <= 16'h0000;
    end else begin
      prev_q <= prev_d;
      cnt_q  <= cnt_d;
    end
  end
  assign sw = (com_o != prev_q) && (prev_q != 8'h00) && (com_o != 8'h00);
  chk_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
  chk_en_write: assert property (wr_i && addr_i == ADDR_PORT1_EN
    |-> ##2 pin_display_en_o[15:8] == $past(wdata_i, 2)) else $error("enable byte");
  chk_bias_write: assert property (wr_i && addr_i == ADDR_OUTPUT_CTRL
    |-> ##2 {7'h00, bias_third_o} == ($past(wdata_i, 2) & 8'h01)) else $error("bias");
  chk_mode_write: assert property (wr_i && addr_i == ADDR_DISPLAY_CTRL
    |-> ##2 {1'b0, led_mode_o, 6'h00} == ($past(wdata_i, 2) & 8'h40)) else $error("mode");
  chk_com_onehot: assert property ($onehot0(com_o)) else $error("commons");
  chk_seg_dark: assert property (com_o == 8'h00 |-> seg_o == 28'h0)
    else $error("segments while stopped");
  chk_slot_len: assert property (sw |-> cnt_q inside {[SLOT-306:SLOT]})
    else $error("slot length");
  chk_com_order: assert property (sw |-> com_o == {prev_q[6:0], 1'b0}
    || prev_q[7] || (prev_q[3] && com_o[0])) else $error("common order");
  chk_fast_div: assert property (sw |-> ##3 (divider_res_o == RES_100K)[*8])
    else $error("fast divider");
  cover property (sw);
  cover property (rd_i ##1 rdata_o != 8'h00);
  cover property (wr_i && addr_i == ADDR_OUTPUT_CTRL);
endmodule
bind sdsd_scan_driver sdsd_checker u_chk (.clock_i(clock_i), .arst_n_i(arst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .com_o(com_o), .seg_o(seg_o), .pin_display_en_o(pin_display_en_o),
  .divider_res_o(divider_res_o), .bias_third_o(bias_third_o),
  .led_mode_o(led_mode_o), .vlcd_o(vlcd_o));

/* File: sdsd_glass_model.sv */
// Display glass model: latches the pattern lit on each driven common
`timescale 1ns/10ps
module sdsd_glass_model (
  // Scan pins
  input  wire logic        clock_i,
  input  wire logic [7:0]  com_i,
  input  wire logic [27:0] seg_i,
  input  wire logic [31:0] pin_en_i,
  // Pattern lit last
  output logic      [27:0] lit_o
);
  // Only pins handed to the display light, and only while a common is driven
  always_ff @(posedge clock_i) begin
    if (com_i != 8'h00) begin
      lit_o <= seg_i & pin_en_i[27:0];
    end
  end
endmodule

/* File: sdsd_pkg.sv */
// Package for the segment display scan driver: register map, fields and timing
package sdsd_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (12-bit register port address space)
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_OUTPUT_CTRL  = 12'h08F;
  localparam logic [11:0] ADDR_DISPLAY_CTRL = 12'h093;
  localparam logic [11:0] ADDR_PORT0_EN     = 12'h09C;
  localparam logic [11:0] ADDR_PORT1_EN     = 12'h094;
  localparam logic [11:0] ADDR_PORT2_EN     = 12'h0A3;
  localparam logic [11:0] ADDR_PORT3_EN     = 12'h0B3;
  localparam logic [11:0] ADDR_RAM_FIRST    = 12'h700;
  localparam logic [11:0] ADDR_RAM_LAST     = 12'h71B;
  localparam logic [11:0] ADDR_SCAN_STATUS  = 12'h0F0;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          DCTRL_SCAN_ON_BIT = 7;
  localparam int          DCTRL_MODE_BIT    = 6;
  localparam int          DCTRL_DUTY_LSB    = 4;
  localparam int          DCTRL_VLCD_LSB    = 0;
  localparam int          OCTRL_RES_LSB     = 2;
  localparam int          OCTRL_MUX_BIT     = 1;
  localparam int          OCTRL_BIAS_BIT    = 0;
  localparam logic [7:0]  OCTRL_WMASK       = 8'hCF;
  localparam logic [7:0]  RESET_BYTE        = 8'h00;
  localparam int          NUM_SEG           = 28;
  localparam int          NUM_COM           = 8;

  // Duty codes
  localparam logic [1:0]  DUTY_EIGHTH  = 2'h0;
  localparam logic [1:0]  DUTY_SIXTH   = 2'h1;
  localparam logic [1:0]  DUTY_FIFTH   = 2'h2;
  localparam logic [1:0]  DUTY_QUARTER = 2'h3;
  // Fast divider code used at each common switch
  localparam logic [1:0]  RES_100K     = 2'h0;

  // ----------------------------------------------------------------------
  // Timing: 32768 Hz scan tick, 64 Hz frame, 16 sub-steps per common slot
  // ----------------------------------------------------------------------
  localparam int CLK_HZ         = 10_000_000;
  localparam int SCAN_HZ        = 32_768;
  localparam int FRAME_HZ       = 64;
  localparam int SUBSTEPS       = 16;
  localparam int TICK_CYC       = CLK_HZ / SCAN_HZ;
  localparam int TICKS_PER_FRAME = SCAN_HZ / FRAME_HZ;

  // Display control fields as a carrier
  typedef struct packed {
    logic       scan_on;
    logic       lcd_led_select;
    logic [1:0] duty;
    logic [3:0] vlcd;
  } sdsd_dctrl_t;

  // Output control fields as a carrier
  typedef struct packed {
    logic [1:0] drive_sel;
    logic [1:0] spare;
    logic [1:0] divider_resistance_sel;
    logic       pin_mux_sel;
    logic       bias_sel;
  } sdsd_octrl_t;

endpackage

/* File: sdsd_scan_driver.sv */
// Segment display scan driver: registers, display RAM and common/segment scan
`timescale 1ns/10ps

module sdsd_scan_driver
  import sdsd_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  // Register port
  input  wire logic [11:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // Display pins
  output logic [NUM_COM-1:0] com_o,
  output logic [NUM_SEG-1:0] seg_o,
  output logic [31:0]        pin_display_en_o,
  // Analog control
  output logic [1:0]         divider_res_o,
  output logic               bias_third_o,
  output logic               led_mode_o,
  output logic [3:0]         vlcd_o
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------

  // First common of the scanned set for a duty code
  function automatic logic [2:0] first_com(input logic [1:0] duty, input logic mux);
    unique case (duty)
      DUTY_EIGHTH:  first_com = 3'h0;
      DUTY_SIXTH:   first_com = 3'h2;
      DUTY_FIFTH:   first_com = 3'h3;
      default:      first_com = mux ? 3'h0 : 3'h4;
    endcase
  endfunction

  // Last common of the scanned set for a duty code
  function automatic logic [2:0] last_com(input logic [1:0] duty, input logic mux);
    last_com = (duty == DUTY_QUARTER && mux) ? 3'h3 : 3'h7;
  endfunction

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  sdsd_dctrl_t dctrl_q, dctrl_d;           // Display control
  sdsd_octrl_t octrl_q, octrl_d;           // Output control
  logic [7:0]  pen_q [4], pen_d [4];       // Per-port pin enables
  logic [7:0]  ram_q [NUM_SEG];            // Display RAM
  logic [7:0]  rdata_d;                    // Read data next value

  // Scan state
  logic [9:0]  tick_cnt_q, tick_cnt_d;     // Divider to 32 kHz tick
  logic [5:0]  sub_q, sub_d;               // Tick count inside common slot, 0 to 63
  logic [2:0]  com_q, com_d;               // Active common index
  logic [NUM_COM-1:0] com_d_vec;           // Common output next value
  logic [NUM_SEG-1:0] seg_d_vec;           // Segment output next value
  logic [1:0]  res_d;                      // Divider resistance next value
  logic        tick;                       // One 32 kHz step

  localparam logic [9:0] TICK_LAST = 10'(TICK_CYC - 1);
  localparam int         SLOT_TICKS = TICKS_PER_FRAME / NUM_COM;
  localparam logic [5:0] SLOT_LAST = 6'(SLOT_TICKS - 1);
  localparam logic [5:0] FAST_LEN  = 6'(SLOT_TICKS / SUBSTEPS);

  // ----------------------------------------------------------------------
  // Register port next values
  // ----------------------------------------------------------------------
  // Decode writes and reads of the control registers
  always_comb begin
    dctrl_d = dctrl_q;
    octrl_d = octrl_q;
    for (int p = 0; p < 4; p++) begin
      pen_d[p] = pen_q[p];
    end
    rdata_d = RESET_BYTE;
    if (wr_i) begin
      unique case (addr_i)
        ADDR_DISPLAY_CTRL: dctrl_d = sdsd_dctrl_t'(wdata_i);
        ADDR_OUTPUT_CTRL:  octrl_d = sdsd_octrl_t'(wdata_i & OCTRL_WMASK);
        ADDR_PORT0_EN:     pen_d[0] = wdata_i;
        ADDR_PORT1_EN:     pen_d[1] = wdata_i;
        ADDR_PORT2_EN:     pen_d[2] = wdata_i;
        ADDR_PORT3_EN:     pen_d[3] = wdata_i;
        default: ;                            // Others ignored
      endcase
    end
    if (rd_i) begin
      if (addr_i >= ADDR_RAM_FIRST && addr_i <= ADDR_RAM_LAST) begin
        rdata_d = ram_q[5'(addr_i - ADDR_RAM_FIRST)];
      end else begin
        unique case (addr_i)
          ADDR_DISPLAY_CTRL: rdata_d = dctrl_q;
          ADDR_OUTPUT_CTRL:  rdata_d = octrl_q;
          ADDR_PORT0_EN:     rdata_d = pen_q[0];
          ADDR_PORT1_EN:     rdata_d = pen_q[1];
          ADDR_PORT2_EN:     rdata_d = pen_q[2];
          ADDR_PORT3_EN:     rdata_d = pen_q[3];
          ADDR_SCAN_STATUS:  rdata_d = {4'h0, dctrl_q.scan_on, com_q};
          default:           rdata_d = RESET_BYTE; // Unmapped reads zero
        endcase
      end
    end
  end

  // Register the control state and read data
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dctrl_q <= sdsd_dctrl_t'(RESET_BYTE);
      octrl_q <= sdsd_octrl_t'(RESET_BYTE);
      for (int p = 0; p < 4; p++) begin
        pen_q[p] <= RESET_BYTE;
      end
      rdata_o <= RESET_BYTE;
    end else begin
      dctrl_q <= dctrl_d;
      octrl_q <= octrl_d;
      for (int p = 0; p < 4; p++) begin
        pen_q[p] <= pen_d[p];
      end
      rdata_o <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // Display RAM: one byte per segment
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_SEG; g++) begin : g_ram
      logic [7:0] byte_d;
      // Byte write when the address hits this segment
      always_comb begin
        byte_d = ram_q[g];
        if (wr_i && addr_i == ADDR_RAM_FIRST + 12'(g)) begin
          byte_d = wdata_i;
        end
      end
      // Hold the byte
      always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          ram_q[g] <= RESET_BYTE;
        end else begin
          ram_q[g] <= byte_d;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------------
  assign tick = (tick_cnt_q == TICK_LAST);

  // Step the tick divider, slot counter and active common
  always_comb begin
    tick_cnt_d = tick ? 10'h000 : tick_cnt_q + 10'h001;
    sub_d      = sub_q;
    com_d      = com_q;
    com_d_vec  = '0;
    seg_d_vec  = '0;
    res_d      = octrl_q.divider_resistance_sel;
    if (!dctrl_q.scan_on) begin
      // Scan stopped: park on first common, outputs idle
      // Park on the first common of the set being written, so that a start
      // that changes duty in the same write begins on the right common
      tick_cnt_d = 10'h000;
      sub_d      = 6'h00;
      com_d      = first_com(dctrl_d.duty, octrl_d.pin_mux_sel);
    end else begin
      if (tick) begin
        if (sub_q == SLOT_LAST) begin
          sub_d = 6'h00;
          if (com_q >= last_com(dctrl_q.duty, octrl_q.pin_mux_sel)) begin
            com_d = first_com(dctrl_q.duty, octrl_q.pin_mux_sel);
          end else begin
            com_d = com_q + 3'h1;
          end
        end else begin
          sub_d = sub_q + 6'h01;
        end
      end
      if (com_q < first_com(dctrl_q.duty, octrl_q.pin_mux_sel)) begin
        com_d = first_com(dctrl_q.duty, octrl_q.pin_mux_sel);
      end
      if (sub_d < FAST_LEN) begin
        res_d = RES_100K;
      end
      com_d_vec[com_d] = 1'b1;
      for (int s = 0; s < NUM_SEG; s++) begin
        seg_d_vec[s] = ram_q[s][com_d];
      end
      if (dctrl_q.duty == DUTY_QUARTER && octrl_q.pin_mux_sel) begin
        seg_d_vec[3:0] = 4'h0;
      end
    end
  end

  // Register scan state and pin outputs
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt_q       <= 10'h000;
      sub_q            <= 6'h00;
      com_q            <= 3'h0;
      com_o            <= '0;
      seg_o            <= '0;
      pin_display_en_o <= 32'h0000_0000;
      divider_res_o    <= RES_100K;
      bias_third_o     <= 1'b0;
      led_mode_o       <= 1'b0;
      vlcd_o           <= 4'h0;
    end else begin
      tick_cnt_q       <= tick_cnt_d;
      sub_q            <= sub_d;
      com_q            <= com_d;
      com_o            <= com_d_vec;
      seg_o            <= seg_d_vec;
      pin_display_en_o <= {pen_q[3], pen_q[2], pen_q[1], pen_q[0]};
      divider_res_o    <= res_d;
      bias_third_o     <= octrl_q.bias_sel;
      led_mode_o       <= dctrl_q.lcd_led_select;
      vlcd_o           <= dctrl_q.vlcd;
    end
  end

endmodule

/* File: segment_display_scan_driver_tb_top.sv */
// Self-checking testbench for the segment display scan driver
`timescale 1ns/10ps
module segment_display_scan_driver_tb_top
  import sdsd_pkg::*;
;
  logic        clock_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [7:0]  rdata_o, com_o, d;
  logic [27:0] seg_o, lit;
  logic [31:0] pin_display_en_o;
  logic [1:0]  divider_res_o, rc;
  logic        bias_third_o, led_mode_o;
  logic [3:0]  vlcd_o;
  logic [7:0]  mdl [int]; // Register and RAM model
  logic [11:0] ea [4] = '{ADDR_PORT0_EN, ADDR_PORT1_EN, ADDR_PORT2_EN, ADDR_PORT3_EN};
  logic [1:0]  du [5] = '{DUTY_QUARTER, DUTY_QUARTER, DUTY_SIXTH, DUTY_FIFTH, DUTY_EIGHTH};
  logic        mx [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  int          fc [5] = '{0, 4, 2, 3, 0}; // First common of each set
  int          n_fail = 0;
  int          check_count = 0;
  int          nt;        // Cycles from scan start to the next common
  sdsd_scan_driver dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .com_o(com_o),
    .seg_o(seg_o), .pin_display_en_o(pin_display_en_o), .divider_res_o(divider_res_o),
    .bias_third_o(bias_third_o), .led_mode_o(led_mode_o), .vlcd_o(vlcd_o));
  sdsd_glass_model u_glass (.clock_i(clock_i), .com_i(com_o), .seg_i(seg_o),
    .pin_en_i(pin_display_en_o), .lit_o(lit));
  // Clock
  initial forever #50 clock_i = ~clock_i;
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // Bus write, model updated with the writable bits
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clock_i);
    wr_i <= 1'b0;
    if (a != 12'h3FF) mdl[a] = (a == ADDR_OUTPUT_CTRL) ? (v & OCTRL_WMASK) : v;
  endtask
  // Bus read, compared with the model
  task automatic rd(input logic [11:0] a);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, mdl.exists(a) ? mdl[a] : 8'h00);
  endtask
  // Expected segments for common c, pins 0..3 masked when they serve as commons
  function automatic logic [27:0] expseg(input int c, input logic msk);
    logic [27:0] v;
    for (int s = 0; s < 28; s++) v[s] = mdl[ADDR_RAM_FIRST + s][c] & !(msk && s < 4);
    return v;
  endfunction
  // Verdict
  task automatic conclude();
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (40000) @(posedge clock_i);
    n_fail++;
    conclude();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h6FD37DF3));
    repeat (5) @(posedge clock_i);
    arst_n_i <= 1'b1;
    rd(ADDR_PORT2_EN);
    rd(ADDR_DISPLAY_CTRL);
    foreach (ea[i]) begin
      wr(ea[i], 8'($urandom));
      rd(ea[i]);
    end
    chk(pin_display_en_o, {mdl[ea[3]], mdl[ea[2]], mdl[ea[1]], mdl[ea[0]]});
    for (int i = 0; i < 4; i++) begin
      d = (8'($urandom) & 8'hFE) | 8'(i & 1);
      wr(ADDR_OUTPUT_CTRL, d);
      rd(ADDR_OUTPUT_CTRL);
      chk(bias_third_o, d[0]);
      d = 8'($urandom) & 8'h7F;
      wr(ADDR_DISPLAY_CTRL, d);
      rd(ADDR_DISPLAY_CTRL);
      chk(led_mode_o, d[6]);
      chk(vlcd_o, d[3:0]);
    end
    wr(12'h3FF, 8'hA5);
    rd(12'h3FF);
    for (int s = 0; s < 28; s++) wr(ADDR_RAM_FIRST + 12'(s), 8'($urandom));
    for (int s = 0; s < 28; s++) rd(ADDR_RAM_FIRST + 12'(s));
    foreach (ea[i]) wr(ea[i], 8'hFF);
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_OUTPUT_CTRL, {4'h0, 2'h3, mx[k], 1'b0});
      wr(ADDR_DISPLAY_CTRL, {2'h2, du[k], 4'h0});
      repeat (3) @(posedge clock_i);
      #1;
      chk(com_o, 8'h01 << fc[k]);
      chk(seg_o, expseg(fc[k], mx[k]));
      chk(lit, expseg(fc[k], mx[k]));
      wr(ADDR_DISPLAY_CTRL, 8'h00);
      repeat (3) @(posedge clock_i);
      #1;
      chk(com_o, 8'h00);
    end
    rc = 2'($urandom % 3) + 2'h1;
    wr(ADDR_OUTPUT_CTRL, {4'h0, rc, 2'h2});
    wr(ADDR_DISPLAY_CTRL, 8'hB0);
    for (nt = 0; nt < 21000 && com_o !== 8'h02; nt++) begin
      @(posedge clock_i);
      #1;
    end
    chk(nt, TICK_CYC * (SCAN_HZ / FRAME_HZ / NUM_COM));
    chk(com_o, 8'h02);
    chk(divider_res_o, RES_100K);
    chk(seg_o, expseg(1, 1'b1));
    repeat (1300) @(posedge clock_i);
    #1;
    chk(divider_res_o, rc);
    conclude();
  end
endmodule
